// ==== src/ctm_clksel.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctm_clksel (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic high_clock_tick,
   input wire logic time_base_tick,
   input wire logic external_clock_pin,
   ctm_if.clk_mp cif
);
   import ctm_pkg::*;
   logic [1:0] sys_div_r;
   logic [5:0] h_div_r;
   logic s1_r, s2_r, s3_r, filt_r;
   logic ext_rise, ext_fall;

   // ---------------------------------------------------------------
   // Prescalers, stopped while the timer is off to save power
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         sys_div_r <= 2'h0;
      else if (cif.run)
         sys_div_r <= sys_div_r + 2'h1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         h_div_r <= 6'h00;
      else if (cif.run && high_clock_tick)
         h_div_r <= h_div_r + 6'h01;
   end

   // ---------------------------------------------------------------
   // External pin: three flops, accepted once the last two agree
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         filt_r <= 1'b0;
      end
      else
      begin
         s1_r <= external_clock_pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            filt_r <= s3_r;
      end
   end
   assign ext_rise = (s2_r == s3_r) && s3_r && !filt_r;
   assign ext_fall = (s2_r == s3_r) && !s3_r && filt_r;

   always_comb
   begin
      case (cif.cks) // R15
         CKS_SYS4: cif.tick = sys_div_r == SYS4_LAST;
         CKS_SYS: cif.tick = 1'b1;
         CKS_H16: cif.tick = high_clock_tick && (h_div_r & H16_MASK) == H16_MASK;
         CKS_H64: cif.tick = high_clock_tick && h_div_r == H64_LAST;
         CKS_TBC: cif.tick = time_base_tick;
         CKS_RISE: cif.tick = ext_rise;
         CKS_FALL: cif.tick = ext_fall;
         default: cif.tick = 1'b0; // R16
      endcase
   end
endmodule : ctm_clksel
`default_nettype wire

// ==== src/ctm_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface ctm_if;
   logic [2:0] cks;
   logic run;
   logic tick;
   logic [1:0] mode;
   logic [1:0] io;
   logic oc;
   logic pol;
   logic dpx;
   logic on;
   logic on_rise;
   logic a_event;
   logic [9:0] cnt;
   logic [9:0] cmpa;
   logic [2:0] rp;
   logic pin;
   logic pin_n;
   logic pin_oe;
   modport clk_mp (input cks, input run, output tick);
   modport out_mp (input mode, input io, input oc, input pol, input dpx,
                   input on, input on_rise, input a_event, input cnt,
                   input cmpa, input rp,
                   output pin, output pin_n, output pin_oe);
endinterface : ctm_if
`default_nettype wire

// ==== src/ctm_outpin.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctm_outpin (
   input wire logic clk_sys,
   input wire logic rst_n,
   ctm_if.out_mp oif
);
   import ctm_pkg::*;
   logic lvl_r;
   logic pwm_lvl;
   logic pwm_act;
   logic [9:0] duty;
   logic drive;

   // ---------------------------------------------------------------
   // Compare match level
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         lvl_r <= 1'b0;
      else if (oif.on_rise)
         lvl_r <= oif.oc; // R17
      else if (oif.mode == MODE_CMO && oif.a_event)
      begin
         case (oif.io)
            IO_LOW: lvl_r <= 1'b0;
            IO_HIGH: lvl_r <= 1'b1;
            IO_TOGGLE: lvl_r <= !lvl_r;
            default: lvl_r <= lvl_r;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Edge aligned PWM; duty source swaps with the duplex bit
   // ---------------------------------------------------------------
   assign duty = oif.dpx ? period_top(oif.rp) : oif.cmpa;
   assign pwm_act = oif.cnt < duty;
   always_comb
   begin
      case (oif.io)
         PWM_ACTIVE: pwm_lvl = oif.oc;
         PWM_OUTPUT: pwm_lvl = pwm_act ? oif.oc : !oif.oc;
         default: pwm_lvl = !oif.oc;
      endcase
   end
   assign drive = (oif.mode == MODE_PWM ? pwm_lvl : lvl_r) ^ oif.pol;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         oif.pin <= 1'b0;
         oif.pin_n <= 1'b1;
         oif.pin_oe <= 1'b0;
      end
      else
      begin
         oif.pin <= drive; // R20
         oif.pin_n <= !drive; // R20
         oif.pin_oe <= oif.on &&
                       (oif.mode == MODE_CMO || oif.mode == MODE_PWM);
      end
   end
endmodule : ctm_outpin
`default_nettype wire

// ==== src/ctm_pkg.sv ====
package ctm_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 3;
   localparam logic [2:0] ADDR_CTRL_A = 3'h0;
   localparam logic [2:0] ADDR_CTRL_B = 3'h1;
   localparam logic [2:0] ADDR_CNT_L = 3'h2;
   localparam logic [2:0] ADDR_CNT_H = 3'h3;
   localparam logic [2:0] ADDR_CMPA_L = 3'h4;
   localparam logic [2:0] ADDR_CMPA_H = 3'h5;
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [7:0] CTRL_B_RST = 8'h00;
   localparam logic [9:0] CMPA_RST = 10'h000;
   localparam logic [9:0] CNT_RST = 10'h000;
   localparam logic [7:0] BUF_RST = 8'h00;
   localparam logic [7:0] RDATA_IDLE = 8'h00;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CA_PAUSE = 7;
   localparam int CA_CKS_LO = 4;
   localparam int CA_ON = 3;
   localparam int CA_RP_LO = 0;
   localparam int CB_MODE_LO = 6;
   localparam int CB_IO_LO = 4;
   localparam int CB_OC = 3;
   localparam int CB_POL = 2;
   localparam int CB_DPX = 1;
   localparam int CB_CCLR = 0;
   // ---------------------------------------------------------------
   // Codes
   // ---------------------------------------------------------------
   localparam logic [2:0] CKS_SYS4 = 3'h0;
   localparam logic [2:0] CKS_SYS = 3'h1;
   localparam logic [2:0] CKS_H16 = 3'h2;
   localparam logic [2:0] CKS_H64 = 3'h3;
   localparam logic [2:0] CKS_TBC = 3'h4;
   localparam logic [2:0] CKS_RISE = 3'h6;
   localparam logic [2:0] CKS_FALL = 3'h7;
   localparam logic [1:0] MODE_CMO = 2'h0;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] IO_LOW = 2'h1;
   localparam logic [1:0] IO_HIGH = 2'h2;
   localparam logic [1:0] IO_TOGGLE = 2'h3;
   localparam logic [1:0] PWM_ACTIVE = 2'h1;
   localparam logic [1:0] PWM_OUTPUT = 2'h2;
   localparam logic [9:0] CNT_MAX = 10'h3FF;
   localparam logic [1:0] SYS4_LAST = 2'h3;
   localparam logic [5:0] H16_MASK = 6'h0F;
   localparam logic [5:0] H64_LAST = 6'h3F;

   // Period field times 128 timer clocks; zero means run to overflow
   function automatic logic [9:0] period_top(input logic [2:0] rp);
      return {rp, 7'h00}; // R7
   endfunction : period_top
endpackage : ctm_pkg

// ==== src/ctm_top.sv ====
// How it works
// R1: Compare low-byte write lands only in the shared holding buffer.
// R2: Compare high write sets high bits and copies buffer to low byte.
// R3: High-byte read returns high bits, latches low byte into buffer.
// R4: Software writes low then high, reads high then low.
// R5: Ten-bit up-counter advances on the selected timer clock.
// R6: Period field meets counter bits 9..7; compare A meets all bits.
// R7: Period code 0 gives 1024 clocks, others code times 128.
// R8: Period code zero lets the counter overflow instead of matching.
// R9: With clear select low, a period match zeroes the counter; in PWM mode the duplex bit selects the clear source instead.
// R10: Software never writes the counter; enable rising is its only software clear.
// R11: Counter clears on overflow or selected match, raising a request.
// R12: Enable rising clears the counter; enable falling holds it.
// R13: Enable low stops counting and powers the timer down.
// R14: Pause bit freezes the count while powered; clearing resumes.
// R15: Clock select picks sys/4, sys, high/16, high/64, base, pin edges.
// R16: Clock select code 101 disconnects the clock entirely.
// R17: Enable rising returns the output pin to its initial level.
// R18: Counter is a read-only pair; compare A a read/write pair.
// R19: High-byte registers read zero in bits 7..2.
// R20: One or two output pins carry the waveform and its inverse.
// R21: With clear select high, a compare A match zeroes the counter; in PWM mode the duplex bit selects the clear source instead.
// R22: Separate request pulses for compare A and period matches.
// R23: Period match is bits 9..7 equal nonzero field, once per step.
`timescale 1ns/1ps
`default_nettype none
module ctm_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ctm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic high_clock_tick,
   input wire logic time_base_tick,
   input wire logic external_clock_pin,
   output logic timer_output_pin,
   output logic timer_output_pin_n,
   output logic timer_output_en,
   output logic irq_a,
   output logic irq_p,
   output logic timer_powered
);
   import ctm_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [7:0] ctrl_a_r;
   logic [7:0] ctrl_b_r;
   logic [9:0] cnt_r;
   logic [9:0] cnt_nxt;
   logic [9:0] cmpa_r;
   logic [7:0] hold_buf_r;
   logic [7:0] rdata_r;
   logic on_d_r;
   logic irq_a_r;
   logic irq_p_r;
   logic powered_r;

   // ---------------------------------------------------------------
   // Field decode
   // ---------------------------------------------------------------
   logic on_bit;
   logic pause_bit;
   logic [2:0] cks;
   logic [2:0] rp;
   logic [1:0] mode;
   logic cclr;
   logic dpx;
   logic on_rise;
   logic tick;
   logic step;
   logic [9:0] cnt_inc;
   logic p_hit;
   logic a_hit;
   logic ovf;
   logic clear_by_a;
   logic clr;
   logic wr_ctrl_a;
   logic wr_ctrl_b;
   logic wr_cmpa_l;
   logic wr_cmpa_h;
   logic rd_cnt_h;
   logic rd_cmpa_h;

   assign on_bit = ctrl_a_r[CA_ON];
   assign pause_bit = ctrl_a_r[CA_PAUSE];
   assign cks = ctrl_a_r[CA_CKS_LO +: 3];
   assign rp = ctrl_a_r[CA_RP_LO +: 3];
   assign mode = ctrl_b_r[CB_MODE_LO +: 2];
   assign cclr = ctrl_b_r[CB_CCLR];
   assign dpx = ctrl_b_r[CB_DPX];

   assign wr_ctrl_a = reg_wr && reg_addr == ADDR_CTRL_A;
   assign wr_ctrl_b = reg_wr && reg_addr == ADDR_CTRL_B;
   assign wr_cmpa_l = reg_wr && reg_addr == ADDR_CMPA_L;
   assign wr_cmpa_h = reg_wr && reg_addr == ADDR_CMPA_H;
   assign rd_cnt_h = reg_rd && reg_addr == ADDR_CNT_H;
   assign rd_cmpa_h = reg_rd && reg_addr == ADDR_CMPA_H;

   // ---------------------------------------------------------------
   // Sub blocks
   // ---------------------------------------------------------------
   ctm_if tif ();

   assign tif.cks = cks;
   assign tif.run = on_bit;
   assign tick = tif.tick;
   assign tif.mode = mode;
   assign tif.io = ctrl_b_r[CB_IO_LO +: 2];
   assign tif.oc = ctrl_b_r[CB_OC];
   assign tif.pol = ctrl_b_r[CB_POL];
   assign tif.dpx = dpx;
   assign tif.on = on_bit;
   assign tif.on_rise = on_rise;
   assign tif.a_event = step && a_hit;
   assign tif.cnt = cnt_r;
   assign tif.cmpa = cmpa_r;
   assign tif.rp = rp;

   ctm_clksel u_clksel (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .high_clock_tick(high_clock_tick),
      .time_base_tick(time_base_tick),
      .external_clock_pin(external_clock_pin),
      .cif(tif.clk_mp)
   );

   ctm_outpin u_outpin (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .oif(tif.out_mp)
   );

   // ---------------------------------------------------------------
   // Enable edge
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         on_d_r <= 1'b0;
      else
         on_d_r <= on_bit;
   end
   assign on_rise = on_bit && !on_d_r;

   // ---------------------------------------------------------------
   // Comparators and clear decision
   // ---------------------------------------------------------------
   // Matching on the incremented value makes the period exact:
   // the step that would reach the match value clears instead.
   assign step = tick && on_bit && !pause_bit && !on_rise; // R13 R14
   assign cnt_inc = cnt_r + 10'h001;
   assign p_hit = rp != 3'h0 && cnt_inc[9:7] == rp; // R6 R23
   assign a_hit = cmpa_r != 10'h000 && cnt_inc == cmpa_r; // R6
   assign ovf = cnt_r == CNT_MAX;
   // PWM reuses the duplex bit as the clear source
   assign clear_by_a = (mode == MODE_PWM) ? dpx : cclr;

   always_comb
   begin
      if (clear_by_a)
         clr = step && a_hit; // R21
      else
         clr = step && p_hit; // R9
   end

   // ---------------------------------------------------------------
   // Counter
   // ---------------------------------------------------------------
   always_comb
   begin
      cnt_nxt = cnt_r; // R12
      if (on_rise)
         cnt_nxt = CNT_RST; // R10 R12
      else if (clr)
         cnt_nxt = CNT_RST; // R11
      else if (step)
         cnt_nxt = cnt_inc; // R5 R8
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         cnt_r <= CNT_RST;
      else
         cnt_r <= cnt_nxt;
   end

   // ---------------------------------------------------------------
   // Match requests
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         irq_a_r <= 1'b0;
         irq_p_r <= 1'b0;
      end
      else
      begin
         irq_a_r <= step && a_hit; // R11 R22
         irq_p_r <= step && !clear_by_a &&
                    (p_hit || (rp == 3'h0 && ovf)); // R8 R22
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         powered_r <= 1'b0;
      else
         powered_r <= on_bit; // R13
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         ctrl_a_r <= CTRL_A_RST;
      else if (wr_ctrl_a)
         ctrl_a_r <= reg_wdata;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         ctrl_b_r <= CTRL_B_RST;
      else if (wr_ctrl_b)
         ctrl_b_r <= reg_wdata;
   end

   // ---------------------------------------------------------------
   // Compare A pair through the holding buffer
   // ---------------------------------------------------------------
   // One buffer serves both pairs, so interleaving pair accesses
   // corrupts the low byte; software keeps each pair together.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         hold_buf_r <= BUF_RST;
      else if (wr_cmpa_l)
         hold_buf_r <= reg_wdata; // R1 R4
      else if (rd_cnt_h)
         hold_buf_r <= cnt_r[7:0]; // R3
      else if (rd_cmpa_h)
         hold_buf_r <= cmpa_r[7:0]; // R3
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         cmpa_r <= CMPA_RST;
      else if (wr_cmpa_h)
         cmpa_r <= {reg_wdata[1:0], hold_buf_r}; // R2
   end

   // ---------------------------------------------------------------
   // Read port, data valid one cycle after the strobe
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         rdata_r <= RDATA_IDLE;
      else if (reg_rd)
      begin
         case (reg_addr) // R18
            ADDR_CTRL_A: rdata_r <= ctrl_a_r;
            ADDR_CTRL_B: rdata_r <= ctrl_b_r;
            ADDR_CNT_L: rdata_r <= hold_buf_r; // R3
            ADDR_CNT_H: rdata_r <= {6'h00, cnt_r[9:8]}; // R3 R19
            ADDR_CMPA_L: rdata_r <= hold_buf_r; // R3
            ADDR_CMPA_H: rdata_r <= {6'h00, cmpa_r[9:8]}; // R19
            default: rdata_r <= RDATA_IDLE;
         endcase
      end
      else
         rdata_r <= RDATA_IDLE;
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign reg_rdata = rdata_r;
   assign irq_a = irq_a_r;
   assign irq_p = irq_p_r;
   assign timer_powered = powered_r;
   assign timer_output_pin = tif.pin;
   assign timer_output_pin_n = tif.pin_n;
   assign timer_output_en = tif.pin_oe;
endmodule : ctm_top
`default_nettype wire

// ==== verification/ctm_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctm_cpu_model (
   input wire logic clk_sys,
   output logic [ctm_pkg::ADDR_W-1:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   import ctm_pkg::*;
   initial
   begin
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // ---------------------------------------------------------------
   // Byte access; an idle cycle after each keeps strobes apart
   // ---------------------------------------------------------------
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata;
      @(posedge clk_sys);
   endtask : rd
   task automatic wr10(input logic [ADDR_W-1:0] lo, input logic [9:0] v);
      wr(lo, v[7:0]);
      wr(lo + 3'h1, {6'h00, v[9:8]});
   endtask : wr10
   task automatic rd10(input logic [ADDR_W-1:0] hi, output logic [9:0] v);
      logic [7:0] h;
      logic [7:0] l;
      rd(hi, h);
      rd(hi - 3'h1, l);
      v = {h[1:0], l};
   endtask : rd10
endmodule : ctm_cpu_model
`default_nettype wire

// ==== verification/ctm_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctm_properties (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [ctm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic high_clock_tick,
   input wire logic time_base_tick,
   input wire logic external_clock_pin,
   input wire logic timer_output_pin,
   input wire logic timer_output_pin_n,
   input wire logic timer_output_en,
   input wire logic irq_a,
   input wire logic irq_p,
   input wire logic timer_powered
);
   import ctm_pkg::*;
   // ---------------------------------------------------------------
   // Shadow of the control registers and period gauge
   // ---------------------------------------------------------------
   logic [7:0] ctla_r;
   logic [7:0] ctlb_r;
   logic [10:0] gap_r;
   logic steady_r;
   logic by_a;
   logic [10:0] per;
   assign by_a = (ctlb_r[7:6] == MODE_PWM) ? ctlb_r[CB_DPX] : ctlb_r[CB_CCLR];
   assign per = (ctla_r[2:0] == 3'h0) ? 11'h400 : {1'b0, ctla_r[2:0], 7'h00};
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         ctla_r <= CTRL_A_RST;
         ctlb_r <= CTRL_B_RST;
      end
      else if (reg_wr && reg_addr == ADDR_CTRL_A)
         ctla_r <= reg_wdata;
      else if (reg_wr && reg_addr == ADDR_CTRL_B)
         ctlb_r <= reg_wdata;
   end
   // Gauge saturates so a long idle stretch cannot wrap into a match
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || irq_p)
         gap_r <= 11'h001;
      else if (gap_r != 11'h7FF)
         gap_r <= gap_r + 11'h001;
   end
   // Any control write spoils the interval, so wait for a fresh pulse
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n || (reg_wr && reg_addr <= ADDR_CTRL_B))
         steady_r <= 1'b0;
      else if (irq_p)
         steady_r <= 1'b1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_rdata_quiet: assert property (!reg_rd |=> reg_rdata == RDATA_IDLE)
      else $error("read data not idle");
   chk_high_zero: assert property (reg_rd && (reg_addr == ADDR_CNT_H ||
      reg_addr == ADDR_CMPA_H) |=> reg_rdata[7:2] == 6'h00)
      else $error("high byte upper bits not zero");
   chk_pin_pair: assert property (timer_output_pin_n == !timer_output_pin)
      else $error("output pins not inverse");
   chk_power_follow: assert property (reg_wr && reg_addr == ADDR_CTRL_A
      |-> ##2 timer_powered == $past(reg_wdata[CA_ON], 2))
      else $error("powered does not follow enable");
   chk_p_period: assert property (irq_p && steady_r && !by_a &&
      ctla_r[6:4] == CKS_SYS && !ctla_r[CA_PAUSE] |-> gap_r == per)
      else $error("period request interval wrong");
   chk_no_p_by_a: assert property (by_a && $past(by_a) |-> !irq_p)
      else $error("period request while clearing on compare A");
   chk_en_mode: assert property (timer_output_en
      |-> timer_powered && !$past(ctlb_r[6]))
      else $error("output enabled in wrong state");
   chk_pin_init: assert property ($rose(timer_powered) &&
      ctlb_r[7:6] == MODE_CMO |-> ##[0:2]
      timer_output_pin == (ctlb_r[CB_OC] ^ ctlb_r[CB_POL]))
      else $error("pin not at initial level");
endmodule : ctm_properties
bind ctm_top ctm_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_a(irq_a), .irq_p(irq_p),
   .high_clock_tick(high_clock_tick), .time_base_tick(time_base_tick),
   .external_clock_pin(external_clock_pin), .timer_powered(timer_powered),
   .timer_output_pin(timer_output_pin), .timer_output_en(timer_output_en),
   .timer_output_pin_n(timer_output_pin_n));
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ctm_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic hct = 1'b1;
   logic tbt = 1'b0;
   logic ext = 1'b0;
   logic [7:0] tk = 8'h00;
   logic pin;
   logic pin_n;
   logic pin_en;
   logic irq_a;
   logic irq_p;
   logic pwr;
   int n_fail = 0;
   int checks_done = 0;
   always #12.5 clk_sys = ~clk_sys;
   // Base tick every 8 clocks, pin edge pair every 8 clocks
   always @(posedge clk_sys)
   begin
      tk <= tk + 8'h01;
      tbt <= (tk[2:0] == 3'h0);
      ext <= tk[2];
   end
   ctm_cpu_model cpu (.clk_sys(clk_sys), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata));
   ctm_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .high_clock_tick(hct), .time_base_tick(tbt),
      .external_clock_pin(ext), .timer_output_pin(pin),
      .timer_output_pin_n(pin_n), .timer_output_en(pin_en),
      .irq_a(irq_a), .irq_p(irq_p), .timer_powered(pwr));
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [10:0] e,
      input logic [10:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   // Prescaler phase is free, so rate checks allow a little slack
   task automatic near(input string nm, input logic [10:0] e,
      input logic [10:0] g);
      checks_done++;
      if ($isunknown(g) || g + 11'h003 < e || g > e + 11'h003)
      begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask : near
   task automatic wait_irq(input logic use_a, output logic [10:0] n);
      n = 11'h000;
      do
      begin
         @(posedge clk_sys);
         n++;
         if (n == 11'h7FF)
         begin
            n_fail++;
            $display("[ERR] request wait expected pulse seen none");
            summarize();
         end
      end while ((use_a ? irq_a : irq_p) !== 1'b1);
   endtask : wait_irq
   task automatic t_reset();
      logic [7:0] d;
      cpu.wr(3'h6, 8'hFF);
      for (int a = 0; a < 7; a++)
      begin
         cpu.rd(a[2:0], d);
         chk("reset value", 11'h000, {3'h0, d});
      end
   endtask : t_reset
   task automatic t_clock();
      logic [9:0] v;
      logic [9:0] w;
      logic [10:0] ex [8];
      ex = '{11'h040, 11'h100, 11'h010, 11'h004, 11'h020, 11'h000,
         11'h020, 11'h020};
      for (int c = 0; c < 8; c++)
      begin
         cpu.wr(ADDR_CTRL_A, {1'b0, c[2:0], 4'h8});
         repeat (254) @(posedge clk_sys);
         cpu.wr(ADDR_CTRL_A, {1'b0, c[2:0], 4'h0});
         cpu.rd10(ADDR_CNT_H, v);
         near("clock rate", ex[c], {1'b0, v});
      end
      cpu.wr(ADDR_CNT_L, 8'h55);
      cpu.wr(ADDR_CNT_H, 8'h03);
      repeat (20) @(posedge clk_sys);
      cpu.rd10(ADDR_CNT_H, w);
      chk("held count", {1'b0, v}, {1'b0, w});
   endtask : t_clock
   task automatic t_period();
      logic [10:0] n;
      logic [2:0] f [3];
      f = '{3'h1, 3'h3, 3'h0};
      cpu.wr(ADDR_CTRL_B, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         cpu.wr(ADDR_CTRL_A, {1'b0, CKS_SYS, 1'b1, f[i]});
         wait_irq(1'b0, n);
         wait_irq(1'b0, n);
         chk("period", (f[i] == 3'h0) ? 11'h400 : {1'b0, f[i], 7'h00},
            n);
      end
      cpu.wr(ADDR_CTRL_A, 8'h00);
   endtask : t_period
   task automatic t_compare();
      logic [9:0] v;
      logic [7:0] d;
      logic [10:0] n;
      cpu.wr10(ADDR_CMPA_L, 10'h105);
      cpu.wr(ADDR_CMPA_L, 8'hAA);
      cpu.rd10(ADDR_CMPA_H, v);
      chk("compare a", 11'h105, {1'b0, v});
      cpu.wr(ADDR_CTRL_B, 8'h39);
      cpu.rd(ADDR_CTRL_B, d);
      chk("control b", 11'h039, {3'h0, d});
      cpu.wr(ADDR_CTRL_A, 8'h19);
      repeat (4) @(posedge clk_sys);
      chk("pin init", 11'h001, {10'h000, pin});
      chk("pin inverse", 11'h000, {10'h000, pin_n});
      chk("pin enable", 11'h001, {10'h000, pin_en});
      wait_irq(1'b1, n);
      wait_irq(1'b1, n);
      chk("a period", 11'h105, n);
      wait_irq(1'b1, n);
      repeat (3) @(posedge clk_sys);
      chk("pin toggled", 11'h000, {10'h000, pin});
      cpu.wr(ADDR_CTRL_A, 8'h11);
      cpu.wr(ADDR_CTRL_A, 8'h19);
      repeat (4) @(posedge clk_sys);
      chk("pin reinit", 11'h001, {10'h000, pin});
      // Duplex PWM: compare A sets the period, field times 128 the duty
      cpu.wr(ADDR_CTRL_B, 8'hAA);
      wait_irq(1'b1, n);
      n = 11'h000;
      repeat (261) @(posedge clk_sys) n += {10'h000, pin};
      chk("pwm duty", 11'h080, n);
      cpu.wr(ADDR_CTRL_A, 8'h00);
      cpu.wr(ADDR_CTRL_B, 8'h00);
   endtask : t_compare
   task automatic t_pause();
      logic [9:0] v;
      logic [9:0] w;
      cpu.wr(ADDR_CTRL_B, 8'h0C);
      cpu.wr(ADDR_CTRL_A, 8'h18);
      repeat (30) @(posedge clk_sys);
      chk("pin polarity", 11'h000, {10'h000, pin});
      chk("powered", 11'h001, {10'h000, pwr});
      cpu.wr(ADDR_CTRL_A, 8'h98);
      cpu.rd10(ADDR_CNT_H, v);
      repeat (40) @(posedge clk_sys);
      cpu.rd10(ADDR_CNT_H, w);
      chk("paused", {1'b0, v}, {1'b0, w});
      cpu.wr(ADDR_CTRL_A, 8'h18);
      repeat (40) @(posedge clk_sys);
      cpu.rd10(ADDR_CNT_H, w);
      near("resumed", {1'b0, v} + 11'h029, {1'b0, w});
      cpu.wr(ADDR_CTRL_A, 8'h00);
   endtask : t_pause
   initial
   begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_clock();
      t_period();
      t_compare();
      t_pause();
      summarize();
   end
endmodule : testbench
`default_nettype wire
